/* logic/cpm_consts.svh */
// Constants for the character processor mailbox and memory decode block
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH
`define CPM_DATA_W        8
`define CPM_ADDR_W        16
`define CPM_FIFO_DEPTH    4
`define CPM_FIFO_PTR_W    2
`define CPM_FIFO_CNT_W    3
`define CPM_PHASE_DIV     5'd24
`define CPM_PHASE_DIV_W   5
`define CPM_BIT_A15       15
`define CPM_BIT_A14       14
`define CPM_HI_BASE       8
`define CPM_RAM_TOP_LO    11
`define CPM_RAM_TOP_HI    13
`define CPM_BYTE_ZERO     8'h00
`define CPM_RAM_TOP_ZERO  3'h0
`endif

/* logic/cpm_pkg.sv */
// Types shared by the mailbox and memory decode block
package cpm_pkg;
    typedef enum logic [1:0] {
        CPM_MEM_NONE = 2'b00,
        CPM_MEM_ROM1 = 2'b01,
        CPM_MEM_ROM2 = 2'b10,
        CPM_MEM_RAM  = 2'b11
    } cpm_mem_sel_t;
endpackage : cpm_pkg

/* logic/cpm_fifo.sv */
// Outbound FIFO module is kept beside the mailbox logic in the principal design file

/* logic/cpm_mailbox.sv */
// Character processor mailbox, address latch, phase clocks and memory decode
// What this block does
// - Host write strobe sets handshake, raises interrupts
// - Processor read or host request clears handshake
// - Inbound byte captured on set, driven on read
// - Outbound byte captured at processor write end
// - Ready low while outbound byte awaits host
// - Address latch captures high byte on strobe
// - Two opposite phase clocks from input clock
// - Vertical sync and blank presented as interrupts
// - Memory enables only in memory cycles
// - Decode bits 15 and 14 into ROM/RAM
// - Single large ROM option; RAM is 2K
`timescale 1ns/100ps
`include "cpm_consts.svh"
module cpm_mailbox (
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   sys_rst_in,
    // Host side
    input  wire logic                   host_write_n_in,
    input  wire logic                   host_read_n_in,
    input  wire logic                   host_read_request_n_in,
    input  wire logic [`CPM_DATA_W-1:0] host_data_in,
    output logic      [`CPM_DATA_W-1:0] host_data_out,
    output logic                        host_data_oe_out,
    output logic                        host_write_ready_out,
    // Processor bus
    input  wire logic                   cp_mailbox_read_n_in,
    input  wire logic                   cp_mailbox_write_n_in,
    input  wire logic                   cp_addr_strobe_in,
    input  wire logic                   cp_io_not_mem_in,
    input  wire logic                   address_bit_15_in,
    input  wire logic [`CPM_DATA_W-1:0] cp_ad_in,
    output logic      [`CPM_DATA_W-1:0] cp_ad_out,
    output logic                        cp_ad_oe_out,
    output logic      [`CPM_DATA_W-1:0] latched_address_out,
    // Processor interrupts and status
    output logic                        cp_serial_in_out,
    output logic                        cp_restart_65_out,
    output logic                        cp_ready_n_out,
    output logic                        cp_vsync_int_out,
    output logic                        cp_vblank_int_out,
    input  wire logic                   vsync_start_in,
    input  wire logic                   vertical_blank_active_in,
    // Clocks to the processor
    output logic                        phase_clock_a_out,
    output logic                        phase_clock_b_out,
    // Memory decode
    input  wire logic                   single_rom_fitted_in,
    output logic                        first_rom_enable_out,
    output logic                        second_rom_enable_out,
    output logic                        ram_enable_out
);
    // ==========================================================
    // Decode function
    // ==========================================================
    function automatic cpm_pkg::cpm_mem_sel_t mem_decode(
        input logic io_sel, input logic a15, input logic a14,
        input logic single, input logic [2:0] top);
        cpm_pkg::cpm_mem_sel_t sel;
        sel = cpm_pkg::CPM_MEM_NONE;
        if (!io_sel) begin
            case ({a15, a14})
                2'b00:   sel = cpm_pkg::CPM_MEM_ROM1;
                2'b01:   sel = single ? cpm_pkg::CPM_MEM_ROM1 : cpm_pkg::CPM_MEM_ROM2;
                2'b10:   sel = (top == `CPM_RAM_TOP_ZERO) ? cpm_pkg::CPM_MEM_RAM
                                                          : cpm_pkg::CPM_MEM_NONE;
                default: sel = cpm_pkg::CPM_MEM_NONE;
            endcase
        end
        return sel;
    endfunction : mem_decode

    // ==========================================================
    // State declarations
    // ==========================================================
    logic                       handshake_ff, nxt_handshake;
    logic [`CPM_DATA_W-1:0]     inbound_ff, nxt_inbound;
    logic                       host_wr_d_ff, nxt_host_wr_d;
    logic                       cp_wr_d_ff, nxt_cp_wr_d;
    logic                       host_rd_d_ff, nxt_host_rd_d;
    logic [`CPM_DATA_W-1:0]     cp_wr_byte_ff, nxt_cp_wr_byte;
    logic [`CPM_DATA_W-1:0]     outbound_ff, nxt_outbound;
    logic                       out_full_ff, nxt_out_full;
    logic [`CPM_DATA_W-1:0]     host_data_ff, nxt_host_data;
    logic                       host_oe_ff, nxt_host_oe;
    logic [`CPM_DATA_W-1:0]     cp_ad_ff, nxt_cp_ad;
    logic                       cp_oe_ff, nxt_cp_oe;
    logic [`CPM_DATA_W-1:0]     latch_ff, nxt_latch;
    logic                       a14_ff, nxt_a14;
    logic [2:0]                 top_ff, nxt_top;
    logic [`CPM_PHASE_DIV_W-1:0] div_ff, nxt_div;
    logic                       phase_ff, nxt_phase;
    logic                       vs_ff, vb_ff;
    logic                       rom1_ff, rom2_ff, ram_ff;
    logic                       ready_n_ff, nxt_ready_n;
    logic                       wr_rdy_ff, nxt_wr_rdy, phase_b_ff, nxt_phase_b;
    logic                       fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [`CPM_DATA_W-1:0]     fifo_out_data;
    logic                       cp_wr_end, host_rd_end;
    cpm_pkg::cpm_mem_sel_t      mem_sel;

    // Strobe edges
    assign cp_wr_end   = !cp_wr_d_ff && cp_mailbox_write_n_in;
    assign host_rd_end = !host_rd_d_ff && host_read_n_in;
    assign fifo_pop    = fifo_out_valid && !out_full_ff;

    // ==========================================================
    // Outbound buffer from processor
    // ==========================================================
    cpm_fifo #(
        .WIDTH (`CPM_DATA_W),
        .DEPTH (`CPM_FIFO_DEPTH)
    ) u_out_fifo (
        .core_clk_in   (core_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (cp_wr_end),
        .in_data_in    (cp_wr_byte_ff),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_pop)
    );

    // ==========================================================
    // Mailbox next state
    // ==========================================================
    always_comb begin
        nxt_host_wr_d  = host_write_n_in;
        nxt_cp_wr_d    = cp_mailbox_write_n_in;
        nxt_host_rd_d  = host_read_n_in;
        nxt_handshake  = handshake_ff;
        nxt_inbound    = inbound_ff;
        nxt_cp_wr_byte = cp_mailbox_write_n_in ? cp_wr_byte_ff : cp_ad_in;
        nxt_outbound   = outbound_ff;
        nxt_out_full   = out_full_ff;
        // Clear first so a new set in the same cycle wins
        if (!cp_mailbox_read_n_in || !host_read_request_n_in) begin
            nxt_handshake = 1'b0;
        end
        if (host_wr_d_ff && !host_write_n_in) begin
            nxt_handshake = 1'b1;
            nxt_inbound   = host_data_in;
        end
        // Host read consumes the outbound byte
        if (host_rd_end) begin
            nxt_out_full = 1'b0;
        end
        if (fifo_pop) begin
            nxt_outbound = fifo_out_data;
            nxt_out_full = 1'b1;
        end
        nxt_ready_n   = !(nxt_out_full || fifo_out_valid);
        nxt_wr_rdy    = fifo_in_ready && !cp_wr_end && cp_mailbox_write_n_in;
        nxt_host_data = outbound_ff;
        nxt_host_oe   = !host_read_n_in;
        nxt_cp_ad     = inbound_ff;
        nxt_cp_oe     = !cp_mailbox_read_n_in;
    end

    // ==========================================================
    // Address latch and decode next state
    // ==========================================================
    always_comb begin
        nxt_latch = latch_ff;
        nxt_a14   = a14_ff;
        nxt_top   = top_ff;
        if (cp_addr_strobe_in) begin
            nxt_latch = cp_ad_in;
            nxt_a14   = cp_ad_in[`CPM_BIT_A14-`CPM_HI_BASE];
            nxt_top   = cp_ad_in[`CPM_RAM_TOP_HI-`CPM_HI_BASE:`CPM_RAM_TOP_LO-`CPM_HI_BASE];
        end
        mem_sel = mem_decode(cp_io_not_mem_in, address_bit_15_in, a14_ff,
                             single_rom_fitted_in, top_ff);
    end

    // ==========================================================
    // Phase clock divider
    // ==========================================================
    always_comb begin
        nxt_div   = div_ff + 1'b1;
        nxt_phase = phase_ff;
        if (div_ff == `CPM_PHASE_DIV) begin
            nxt_div   = '0;
            nxt_phase = !phase_ff;
        end
        nxt_phase_b = !nxt_phase;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            handshake_ff  <= 1'b0;
            inbound_ff    <= `CPM_BYTE_ZERO;
            host_wr_d_ff  <= 1'b1;
            cp_wr_d_ff    <= 1'b1;
            host_rd_d_ff  <= 1'b1;
            cp_wr_byte_ff <= `CPM_BYTE_ZERO;
            outbound_ff   <= `CPM_BYTE_ZERO;
            out_full_ff   <= 1'b0;
            ready_n_ff    <= 1'b1;
            host_data_ff  <= `CPM_BYTE_ZERO;
            host_oe_ff    <= 1'b0;
            cp_ad_ff      <= `CPM_BYTE_ZERO;
            cp_oe_ff      <= 1'b0;
            latch_ff      <= `CPM_BYTE_ZERO;
            a14_ff        <= 1'b0;
            top_ff        <= `CPM_RAM_TOP_ZERO;
            div_ff        <= '0;
            phase_ff      <= 1'b0;
            phase_b_ff    <= 1'b1;
            wr_rdy_ff     <= 1'b0;
            vs_ff         <= 1'b0;
            vb_ff         <= 1'b0;
            rom1_ff       <= 1'b0;
            rom2_ff       <= 1'b0;
            ram_ff        <= 1'b0;
        end else begin
            handshake_ff  <= nxt_handshake;
            inbound_ff    <= nxt_inbound;
            host_wr_d_ff  <= nxt_host_wr_d;
            cp_wr_d_ff    <= nxt_cp_wr_d;
            host_rd_d_ff  <= nxt_host_rd_d;
            cp_wr_byte_ff <= nxt_cp_wr_byte;
            outbound_ff   <= nxt_outbound;
            out_full_ff   <= nxt_out_full;
            ready_n_ff    <= nxt_ready_n;
            host_data_ff  <= nxt_host_data;
            host_oe_ff    <= nxt_host_oe;
            cp_ad_ff      <= nxt_cp_ad;
            cp_oe_ff      <= nxt_cp_oe;
            latch_ff      <= nxt_latch;
            a14_ff        <= nxt_a14;
            top_ff        <= nxt_top;
            div_ff        <= nxt_div;
            phase_ff      <= nxt_phase;
            phase_b_ff    <= nxt_phase_b;
            wr_rdy_ff     <= nxt_wr_rdy;
            vs_ff         <= vsync_start_in;
            vb_ff         <= vertical_blank_active_in;
            rom1_ff       <= (mem_sel == cpm_pkg::CPM_MEM_ROM1);
            rom2_ff       <= (mem_sel == cpm_pkg::CPM_MEM_ROM2);
            ram_ff        <= (mem_sel == cpm_pkg::CPM_MEM_RAM);
        end
    end

    // ==========================================================
    // Outputs straight from flip-flops
    // ==========================================================
    assign host_data_out         = host_data_ff;
    assign host_data_oe_out      = host_oe_ff;
    assign host_write_ready_out  = wr_rdy_ff;
    assign cp_ad_out             = cp_ad_ff;
    assign cp_ad_oe_out          = cp_oe_ff;
    assign latched_address_out   = latch_ff;
    assign cp_serial_in_out      = handshake_ff;
    assign cp_restart_65_out     = handshake_ff;
    assign cp_ready_n_out        = ready_n_ff;
    assign cp_vsync_int_out      = vs_ff;
    assign cp_vblank_int_out     = vb_ff;
    assign phase_clock_a_out     = phase_ff;
    assign phase_clock_b_out     = phase_b_ff;
    assign first_rom_enable_out  = rom1_ff;
    assign second_rom_enable_out = rom2_ff;
    assign ram_enable_out        = ram_ff;
endmodule : cpm_mailbox

module cpm_fifo #(
    parameter int WIDTH = `CPM_DATA_W,
    parameter int DEPTH = `CPM_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    logic [WIDTH-1:0]            mem_ff [DEPTH];
    logic [`CPM_FIFO_PTR_W-1:0]  wr_ptr_ff, nxt_wr_ptr;
    logic [`CPM_FIFO_PTR_W-1:0]  rd_ptr_ff, nxt_rd_ptr;
    logic [`CPM_FIFO_CNT_W-1:0]  count_ff,  nxt_count;
    logic                        push, pop;

    // Handshake terms
    assign push          = in_valid_in && (count_ff != `CPM_FIFO_CNT_W'(DEPTH));
    assign pop           = out_ready_in && (count_ff != '0);
    assign in_ready_out  = (count_ff != `CPM_FIFO_CNT_W'(DEPTH));
    assign out_valid_out = (count_ff != '0);
    assign out_data_out  = mem_ff[rd_ptr_ff];

    // Pointer and count next values
    always_comb begin
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop  ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_count  = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // Pointer and count registers
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

    // Storage cells
    for (genvar gi = 0; gi < DEPTH; gi++) begin : g_cell
        always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                mem_ff[gi] <= '0;
            end else if (push && (wr_ptr_ff == `CPM_FIFO_PTR_W'(gi))) begin
                mem_ff[gi] <= in_data_in;
            end
        end
    end
endmodule : cpm_fifo

/* testbench/cpm_mailbox_chk.sv */
// Checker bound to the mailbox and memory decode block
`timescale 1ns/100ps
`include "cpm_consts.svh"
module cpm_mailbox_chk (
    // Clock and reset
    input wire logic                   core_clk_in,
    input wire logic                   sys_rst_in,
    // Host side
    input wire logic                   host_write_n_in,
    input wire logic                   host_read_n_in,
    input wire logic                   host_read_request_n_in,
    input wire logic [`CPM_DATA_W-1:0] host_data_in,
    input wire logic                   host_data_oe_out,
    // Processor side
    input wire logic                   cp_mailbox_read_n_in,
    input wire logic                   cp_mailbox_write_n_in,
    input wire logic                   cp_addr_strobe_in,
    input wire logic                   cp_io_not_mem_in,
    input wire logic                   single_rom_fitted_in,
    input wire logic [`CPM_DATA_W-1:0] cp_ad_in,
    input wire logic [`CPM_DATA_W-1:0] cp_ad_out,
    input wire logic                   cp_ad_oe_out,
    input wire logic [`CPM_DATA_W-1:0] latched_address_out,
    // Status, interrupts and clocks
    input wire logic                   cp_serial_in_out,
    input wire logic                   cp_restart_65_out,
    input wire logic                   cp_ready_n_out,
    input wire logic                   vsync_start_in,
    input wire logic                   vertical_blank_active_in,
    input wire logic                   cp_vsync_int_out,
    input wire logic                   cp_vblank_int_out,
    input wire logic                   phase_clock_a_out,
    input wire logic                   phase_clock_b_out,
    // Memory enables
    input wire logic                   first_rom_enable_out,
    input wire logic                   second_rom_enable_out,
    input wire logic                   ram_enable_out
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_flag_set_write: assert property ($fell(host_write_n_in) |=> cp_serial_in_out)
        else $error("flag not set by host write");
    a_flag_pins_same: assert property (cp_serial_in_out == cp_restart_65_out)
        else $error("flag outputs differ");
    a_flag_clear_read: assert property (
        (!cp_mailbox_read_n_in || !host_read_request_n_in) && !$fell(host_write_n_in)
        |=> !cp_serial_in_out) else $error("flag not cleared");
    a_inbound_capture: assert property (
        $fell(host_write_n_in) |-> ##2 cp_ad_out == $past(host_data_in, 2))
        else $error("inbound byte not captured");
    a_cp_drive_read: assert property (cp_ad_oe_out == !$past(cp_mailbox_read_n_in))
        else $error("processor bus drive wrong");
    a_host_drive_read: assert property (host_data_oe_out == !$past(host_read_n_in))
        else $error("host bus drive wrong");
    a_ready_after_push: assert property (
        $rose(cp_mailbox_write_n_in) && cp_ready_n_out |-> ##2 !cp_ready_n_out)
        else $error("ready not lowered");
    a_latch_capture: assert property (
        cp_addr_strobe_in |=> latched_address_out == $past(cp_ad_in))
        else $error("address not latched");
    a_phase_opposite: assert property (phase_clock_a_out != phase_clock_b_out)
        else $error("phase clocks not opposite");
    a_phase_period: assert property (
        $rose(phase_clock_a_out) |-> ##25 $fell(phase_clock_a_out))
        else $error("phase clock period wrong");
    a_sync_copy: assert property (
        {cp_vsync_int_out, cp_vblank_int_out} == $past({vsync_start_in, vertical_blank_active_in}))
        else $error("sync interrupts wrong");
    a_mem_io_quiet: assert property (
        $past(cp_io_not_mem_in)
        |-> !(first_rom_enable_out || second_rom_enable_out || ram_enable_out))
        else $error("memory enable in io cycle");
    a_mem_one_hot: assert property (
        $onehot0({first_rom_enable_out, second_rom_enable_out, ram_enable_out}))
        else $error("several memory enables");
    a_rom2_unused: assert property ($past(single_rom_fitted_in) |-> !second_rom_enable_out)
        else $error("second rom enabled with single rom");
    // Main scenarios reached
    c_host_write: cover property ($rose(cp_serial_in_out));
    c_outbound: cover property ($fell(cp_ready_n_out));
    c_ram_access: cover property (ram_enable_out);
endmodule : cpm_mailbox_chk

bind cpm_mailbox cpm_mailbox_chk cpm_mailbox_chk_i (.*);

/* testbench/cpm_host_model.sv */
// Main CPU side model that writes and reads the mailbox
`timescale 1ns/100ps
`include "cpm_consts.svh"
module cpm_host_model (
    // Clock and returned byte
    input  wire logic                   core_clk_in,
    input  wire logic [`CPM_DATA_W-1:0] byte_in,
    // Strobes and byte to the block
    output logic                        wr_n_out,
    output logic                        rd_n_out,
    output logic                        req_n_out,
    output logic      [`CPM_DATA_W-1:0] byte_out
);
    // Idle levels from time zero
    initial begin
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        req_n_out = 1'b1;
        byte_out = 8'h00;
    end
    // Byte driven while the write strobe is held low for one edge; bus inverted once released
    task automatic write_byte(input logic [`CPM_DATA_W-1:0] b);
        @(posedge core_clk_in) #1;
        byte_out = b;
        wr_n_out = 1'b0;
        @(posedge core_clk_in) #1;
        wr_n_out = 1'b1;
        byte_out = ~b;
    endtask : write_byte
    // Read strobe held two edges; the rising end consumes the byte
    task automatic read_byte(output logic [`CPM_DATA_W-1:0] b);
        @(posedge core_clk_in) #1;
        rd_n_out = 1'b0;
        repeat (2) @(posedge core_clk_in);
        #1;
        b = byte_in;
        rd_n_out = 1'b1;
    endtask : read_byte
    // Request to read back, clears the flag
    task automatic request;
        @(posedge core_clk_in) #1;
        req_n_out = 1'b0;
        @(posedge core_clk_in) #1;
        req_n_out = 1'b1;
    endtask : request
endmodule : cpm_host_model

/* testbench/tb_top.sv */
// Self-checking bench for the mailbox and memory decode block
`timescale 1ns/100ps
`include "cpm_consts.svh"
module tb_top;
    // ==========================================
    // Signals
    logic       core_clk_in = 1'b0, sys_rst_in = 1'b1;
    logic       hw_n, hr_n, hq_n, hoe, wrdy, cpoe, ser, r65, rdy_n, vsi, vbi, pa, pb, r1, r2, ram;
    logic       crd_n = 1'b1, cwr_n = 1'b1, stb = 1'b0, io = 1'b0, a15 = 1'b0;
    logic       single = 1'b0, vs = 1'b0, vb = 1'b0;
    logic [7:0] hd, hdo, cpo, lat, b, cpd = 8'h00;
    logic [7:0] q[$];
    logic [15:0] a;
    logic [15:0] bnd [8] = '{16'h0000, 16'h3fff, 16'h4000, 16'h7fff,
                             16'h8000, 16'h87ff, 16'h8800, 16'hc000};
    logic [31:0] seed = 32'h7580, r;
    int         mismatches = 0, checks_done = 0, n;
    // Clock at 200 MHz
    always #2.5 core_clk_in = ~core_clk_in;
    // Design and host model
    cpm_mailbox cpm_mailbox_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .host_write_n_in(hw_n), .host_read_n_in(hr_n), .host_read_request_n_in(hq_n),
        .host_data_in(hd), .host_data_out(hdo), .host_data_oe_out(hoe),
        .host_write_ready_out(wrdy), .cp_mailbox_read_n_in(crd_n),
        .cp_mailbox_write_n_in(cwr_n), .cp_addr_strobe_in(stb), .cp_io_not_mem_in(io),
        .address_bit_15_in(a15), .cp_ad_in(cpd), .cp_ad_out(cpo), .cp_ad_oe_out(cpoe),
        .latched_address_out(lat), .cp_serial_in_out(ser), .cp_restart_65_out(r65),
        .cp_ready_n_out(rdy_n), .cp_vsync_int_out(vsi), .cp_vblank_int_out(vbi),
        .vsync_start_in(vs), .vertical_blank_active_in(vb), .phase_clock_a_out(pa),
        .phase_clock_b_out(pb), .single_rom_fitted_in(single),
        .first_rom_enable_out(r1), .second_rom_enable_out(r2), .ram_enable_out(ram));
    cpm_host_model cpm_host_model_i (.core_clk_in(core_clk_in), .byte_in(hdo),
        .wr_n_out(hw_n), .rd_n_out(hr_n), .req_n_out(hq_n), .byte_out(hd));
    // ==========================================
    // Helpers
    function automatic logic [31:0] xs;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Expected enables as {first rom, second rom, ram}
    function automatic logic [2:0] mem_expect(input logic i, input logic [15:0] ad, input logic s);
        if (i) return 3'h0;
        if (!ad[15]) return (ad[14] && !s) ? 3'h2 : 3'h4;
        return (!ad[14] && ad[13:11] == 3'h0) ? 3'h1 : 3'h0;
    endfunction : mem_expect
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic tick;
        @(posedge core_clk_in) #1;
    endtask : tick
    // Processor write; a byte counts only if the path had room
    task automatic cp_write(input logic [7:0] d);
        repeat (2) tick;
        if (wrdy === 1'b1) q.push_back(d);
        cwr_n = 1'b0;
        cpd = d;
        tick;
        cwr_n = 1'b1;
        cpd = ~d;
    endtask : cp_write
    task automatic wait_rdy(input logic v);
        for (n = 0; n < 60 && rdy_n !== v; n++) tick;
        if (rdy_n !== v) begin
            chk("ready wait", {7'h0, v}, {7'h0, rdy_n});
            end_of_test();
        end
    endtask : wait_rdy
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk_in);
        #1 sys_rst_in = 1'b0;
        chk("ready after reset", 8'h01, {7'h0, rdy_n});
        // Inbound bytes, last one cleared by a read request
        for (int i = 0; i < 6; i++) begin
            r = xs();
            cpm_host_model_i.write_byte(r[7:0]);
            tick;
            chk("flag", 8'h03, {6'h0, ser, r65});
            if (i == 5) begin
                cpm_host_model_i.request();
                tick;
                chk("flag after request", 8'h00, {7'h0, ser});
            end else begin
                tick;
                crd_n = 1'b0;
                repeat (2) tick;
                chk("inbound byte", r[7:0], cpo);
                chk("inbound drive and flag", 8'h02, {6'h0, cpoe, ser});
                crd_n = 1'b1;
            end
        end
        $display("test inbound done");
        // Fill outbound path with the host stalled until it refuses
        for (int i = 0; i < 8 && q.size() == i; i++) begin
            r = xs();
            cp_write(r[7:0]);
        end
        tick;
        chk("full refuses", 8'h00, {7'h0, wrdy});
        cp_write(8'h5a);
        // Drain in order, ready returns high when empty
        while (q.size() > 0) begin
            wait_rdy(1'b0);
            repeat (3) tick;
            cpm_host_model_i.read_byte(b);
            chk("outbound byte", q.pop_front(), b);
            chk("host drive", 8'h01, {7'h0, hoe});
        end
        wait_rdy(1'b1);
        $display("test outbound done");
        // Decode boundaries first, then random addresses and sync levels
        for (int i = 0; i < 40; i++) begin
            r = xs();
            a = (i < 8) ? bnd[i] : r[15:0];
            tick;
            stb = 1'b1;
            cpd = a[15:8];
            a15 = a[15];
            single = r[17];
            vs = r[18];
            vb = r[19];
            io = (i >= 8) && r[16] && (vs || vb);
            tick;
            stb = 1'b0;
            cpd = ~a[15:8];
            repeat (2) tick;
            chk("latch", a[15:8], lat);
            chk("decode", {5'h0, mem_expect(io, a, single)}, {5'h0, r1, r2, ram});
            chk("sync", {6'h0, vs, vb}, {6'h0, vsi, vbi});
            chk("phase", {7'h0, ~pa}, {7'h0, pb});
        end
        $display("test decode done");
        end_of_test();
    end
endmodule : tb_top
